// *** shared/irs_pkg.sv ***
// Constants, register map and helper functions of the readout sequencer
// ==========================================================================
// Summary of operation
// - Normal mode: sample, reset row, sample again, subtract in the amplifier.
// - Non-destructive enable set: rows read without the per-row reset.
// - Setting field only matters when non-destructive is enabled; four codes.
// - Mode 1: left and right row clocks identical, no electronic shutter.
// - Mode 2: rows read alternately by left and right pointers.
// - Setting 3: left row reset and read, then right row read only.
// - Setting 4: left then right row read, neither reset.
// - Non-destructive readout drives reset buses to the dark reference level.
// - Reset-before-read resets each line, except right row in mode 2.
// - Fast row reset drives left and right row registers identically.
// - Amplifier calibrated each row blanking; 0 coarse, 1 incremental.
// - Frame calibration bit for the first row, line bit for later rows.
// - Continuous column charge replaces per-row precharge.
// - Column shift register clocked at half system rate, odd/even buses.
// - Granularity picks 2,4,8,16 clock sequencer; blanking 142,282,562,1122.
// - Forced black holds black high, disconnects amplifiers, dark bus level.
// - Global pixel hold keeps all pixels in reset while set.
// - Converter clock source bit: 0 internal, 1 external.
// - Transfer-law bit: 0 linear, 1 gamma companding.
// - Bit-flip bit: 0 pass converter bits, 1 invert every bit.
// - Each row clock advances pointer, and integration counter until it equals integration time; mode 2 halves.
package irs_pkg;
   localparam int ROW_W_DEF = 12;
   localparam int ADC_W_DEF = 10;
   localparam int BLANK_W = 11;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_SEQ = 6'h00;
   localparam logic [5:0] IDX_INT = 6'h03;
   localparam logic [5:0] IDX_ADC = 6'h0C;
   localparam logic [5:0] IDX_RSVD_A = 6'h0D;
   localparam logic [5:0] IDX_RSVD_B = 6'h0E;
   localparam logic [5:0] IDX_RSVD_C = 6'h0F;
   localparam logic [5:0] IDX_STATUS = 6'h10;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 7;
   // Sequencer configuration fields
   localparam int SEQ_W = 12;
   localparam int SEQ_NDR = 0;
   localparam int SEQ_SET_LO = 1;
   localparam int SEQ_SET_HI = 2;
   localparam int SEQ_RBR = 3;
   localparam int SEQ_FAST = 4;
   localparam int SEQ_FCAL = 5;
   localparam int SEQ_LCAL = 6;
   localparam int SEQ_CC = 7;
   localparam int SEQ_GRAN_LO = 8;
   localparam int SEQ_GRAN_HI = 9;
   localparam int SEQ_BLACK = 10;
   localparam int SEQ_RALL = 11;
   localparam logic [11:0] SEQ_RST = 12'h100;
   localparam logic [11:0] INT_RST = 12'h001;
   // Converter configuration fields
   localparam int ADC_CFG_W = 11;
   localparam int ADC_EXTCLK = 4;
   localparam int ADC_GAMMA = 9;
   localparam int ADC_FLIP = 10;
   localparam logic [10:0] ADC_RST = 11'h000;
   localparam int STAT_HALF = 16;
   // Non-destructive setting codes
   localparam logic [1:0] ND_M1_RESET = 2'h0;
   localparam logic [1:0] ND_M1_READ = 2'h1;
   localparam logic [1:0] ND_M2_RESET = 2'h2;
   localparam logic [1:0] ND_M2_READ = 2'h3;
   // Row blanking lengths in system clocks per granularity code
   localparam logic [10:0] BLANK_G0 = 11'h08E;
   localparam logic [10:0] BLANK_G1 = 11'h11A;
   localparam logic [10:0] BLANK_G2 = 11'h232;
   localparam logic [10:0] BLANK_G3 = 11'h462;
   localparam logic [10:0] BLANK_ONE = 11'h001;
   localparam logic [4:0] XSEQ_BASE = 5'h02;
   localparam logic [4:0] XSEQ_ONE = 5'h01;

   typedef enum logic {PH_LEFT, PH_RIGHT} irs_phase_t;

   function automatic logic [BLANK_W-1:0] blankLen(input logic [1:0] gran);
      case (gran)
         2'h0: blankLen = BLANK_G0;
         2'h1: blankLen = BLANK_G1;
         2'h2: blankLen = BLANK_G2;
         default: blankLen = BLANK_G3;
      endcase
   endfunction : blankLen

   function automatic logic [4:0] xSeqPeriod(input logic [1:0] gran);
      xSeqPeriod = 5'(XSEQ_BASE << gran);
   endfunction : xSeqPeriod
endpackage : irs_pkg

// *** shared/irs_seq_if.sv ***
// Link between sequencer control and the blanking and column timer
`timescale 1ns/1ps
`default_nettype none
interface irs_seq_if;
   logic [1:0] gran;
   logic start;
   logic blanking;
   logic xSeqTick;
   logic colShiftClk;
   modport timer(input gran, input start, output blanking, output xSeqTick, output colShiftClk);
   modport ctrl(output gran, output start, input blanking, input xSeqTick, input colShiftClk);
endinterface : irs_seq_if
`default_nettype wire

// *** logic/irs_blank_timer.sv ***
// Row blanking timer, X-sequencer divider and column shift clock
`timescale 1ns/1ps
`default_nettype none
module irs_blank_timer (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Link to sequencer control
   irs_seq_if.timer sq
);
   import irs_pkg::*;

   logic [BLANK_W-1:0] blankCnt_r;
   logic [BLANK_W-1:0] runLen_r;
   logic blanking_r;
   logic [1:0] granLat_r;
   logic [4:0] xDiv_r;
   logic xTick_r;
   logic colClk_r;

   // ======================================================================
   // Decode
   wire [BLANK_W-1:0] blankLenNow = blankLen(sq.gran);
   wire [4:0] xPeriod = xSeqPeriod(granLat_r);
   wire blankEnd = blanking_r && (blankCnt_r == BLANK_ONE);
   wire xWrap = (xDiv_r == 5'(xPeriod - XSEQ_ONE));

   // ======================================================================
   // Blanking countdown, restarted by every row clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blankCnt_r <= '0;
         blanking_r <= 1'b0;
         granLat_r <= 2'h0;
      end else if (ce) begin
         if (sq.start) begin
            blankCnt_r <= blankLenNow;
            blanking_r <= 1'b1;
            granLat_r <= sq.gran;
         end else if (blanking_r) begin
            blankCnt_r <= BLANK_W'(blankCnt_r - BLANK_ONE);
            blanking_r <= !blankEnd;
         end
      end
   end

   // ======================================================================
   // Sequencer tick and half-rate column clock
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         xDiv_r <= 5'h00;
         xTick_r <= 1'b0;
         colClk_r <= 1'b0;
      end else if (ce) begin
         xDiv_r <= (sq.start || xWrap) ? 5'h00 : 5'(xDiv_r + XSEQ_ONE);
         xTick_r <= xWrap;
         colClk_r <= !colClk_r;
      end
   end

   assign sq.blanking = blanking_r;
   assign sq.xSeqTick = xTick_r;
   assign sq.colShiftClk = colClk_r;

   // ======================================================================
   // Checks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         runLen_r <= '0;
      end else if (ce) begin
         if (sq.start) begin
            runLen_r <= BLANK_ONE;
         end else if (blanking_r && !blankEnd) begin
            runLen_r <= BLANK_W'(runLen_r + BLANK_ONE);
         end
      end
   end

   chk_blank_length: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(blanking_r) |-> runLen_r == blankLen(granLat_r))
      else $error("row blanking length wrong");
   chk_col_half: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) && $past(ce) |-> colClk_r != $past(colClk_r))
      else $error("column clock not at half rate");
   cov_blank_done: cover property (@(posedge clk) disable iff (sys_rst) $fell(blanking_r));
endmodule : irs_blank_timer
`default_nettype wire

// *** logic/irs_readout_top.sv ***
// Readout sequencer top: APB registers, row sequencing, converter options
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module irs_readout_top #(
   parameter int ROW_W = irs_pkg::ROW_W_DEF,
   parameter int ADC_W = irs_pkg::ADC_W_DEF
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Controller pins
   input wire logic rowClkPin,
   input wire logic frameStartPin,
   // Row drivers
   output logic leftRowClk,
   output logic rightRowClk,
   output logic leftRowReset,
   output logic rightRowReset,
   output logic [ROW_W-1:0] leftPtr,
   output logic [ROW_W-1:0] rightPtr,
   // Analog chain control
   output logic doubleSample,
   output logic resetBusDark,
   output logic blackHold,
   output logic colAmpDisconnect,
   output logic globalPixelReset,
   output logic continuousColumnCharge,
   output logic colPrecharge,
   output logic calActive,
   output logic calCoarse,
   output logic colShiftClk,
   output logic xSeqTick,
   // Converter
   input wire logic [ADC_W-1:0] adcDataIn,
   output logic [ADC_W-1:0] adcDataOut,
   output logic converterClockSource,
   output logic gammaLaw
);
   import irs_pkg::*;

   function automatic logic [ROW_W-1:0] rowInc(input logic [ROW_W-1:0] v);
      rowInc = ROW_W'(v + 1'b1);
   endfunction : rowInc

   logic [SEQ_W-1:0] seqCfg_r;
   logic [ROW_W-1:0] intTime_r;
   logic [ADC_CFG_W-1:0] adcCfg_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [2:0] rowSync_r;
   logic [2:0] frameSync_r;
   logic [ROW_W-1:0] leftPtr_r;
   logic [ROW_W-1:0] rightPtr_r;
   logic [ROW_W-1:0] intCnt_r;
   logic rightActive_r;
   logic firstRow_r;
   irs_phase_t phase_r;
   logic leftRowClk_r;
   logic rightRowClk_r;
   logic leftRowReset_r;
   logic rightRowReset_r;
   logic doubleSample_r;
   logic resetBusDark_r;
   logic blackHold_r;
   logic globalPixelReset_r;
   logic contCharge_r;
   logic colPrecharge_r;
   logic calCoarse_r;
   logic convSrc_r;
   logic gamma_r;
   logic [ADC_W-1:0] adcDataOut_r;

   irs_seq_if sq();

   // ======================================================================
   // APB decode
   wire [5:0] regIdx = paddr[IDX_MSB:IDX_LSB];
   wire hitSeq = (regIdx == IDX_SEQ);
   wire hitInt = (regIdx == IDX_INT);
   wire hitAdc = (regIdx == IDX_ADC);
   wire hitStat = (regIdx == IDX_STATUS);
   wire hitRsvd = (regIdx == IDX_RSVD_A) || (regIdx == IDX_RSVD_B) || (regIdx == IDX_RSVD_C);
   wire hitMapped = hitSeq || hitInt || hitAdc || hitStat || hitRsvd;
   wire setupPhase = psel && !penable;
   wire wrDone = psel && penable && pwrite && pready_r;
   wire [31:0] statusWord = {STAT_HALF'(rightPtr_r), STAT_HALF'(leftPtr_r)};
   // Reserved slots fall through to zero
   wire [31:0] rdMux = hitSeq ? 32'(seqCfg_r) :
                       hitInt ? 32'(intTime_r) :
                       hitAdc ? 32'(adcCfg_r) :
                       hitStat ? statusWord : 32'h0000_0000;

   // ======================================================================
   // APB handshake: no wait state, answer loaded in the setup cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         pready_r <= setupPhase;
         if (setupPhase) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
            pslverr_r <= !hitMapped;
         end
      end
   end

   // ======================================================================
   // Configuration registers; reserved and status writes are dropped
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         seqCfg_r <= SEQ_RST;
         intTime_r <= ROW_W'(INT_RST);
         adcCfg_r <= ADC_RST;
      end else if (ce && wrDone) begin
         if (hitSeq) begin
            seqCfg_r <= pwdata[SEQ_W-1:0];
         end
         if (hitInt) begin
            intTime_r <= pwdata[ROW_W-1:0];
         end
         if (hitAdc) begin
            adcCfg_r <= pwdata[ADC_CFG_W-1:0];
         end
      end
   end

   // ======================================================================
   // Pin synchronisers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rowSync_r <= 3'h0;
         frameSync_r <= 3'h0;
      end else if (ce) begin
         rowSync_r <= {rowSync_r[1:0], rowClkPin};
         frameSync_r <= {frameSync_r[1:0], frameStartPin};
      end
   end

   // ======================================================================
   // Mode decode
   wire ndrOn = seqCfg_r[SEQ_NDR];
   wire [1:0] ndSet = seqCfg_r[SEQ_SET_HI:SEQ_SET_LO];
   wire mode1 = ndrOn && !ndSet[1];
   wire mode2 = ndrOn && ndSet[1];
   wire fastRst = seqCfg_r[SEQ_FAST];
   wire black = seqCfg_r[SEQ_BLACK];
   wire identical = fastRst || mode1;
   wire rowPulse = ce && rowSync_r[1] && !rowSync_r[2];
   wire framePulse = ce && frameSync_r[1] && !frameSync_r[2];
   wire onRight = mode2 && (phase_r == PH_RIGHT);
   // Reset of the row being read
   wire readReset = !ndrOn || (ndSet == ND_M1_RESET) || (ndSet == ND_M2_RESET);
   wire leftResetNxt = !onRight && (readReset || seqCfg_r[SEQ_RBR]);
   // Shutter reset of the right row in normal mode; none in mode 2
   wire rightResetNxt = identical ? leftResetNxt : (!ndrOn && rightActive_r);
   wire leftClkNxt = identical || !onRight;
   wire rightClkNxt = identical || onRight || (!ndrOn && rightActive_r);
   wire advance = !mode2 || onRight;
   wire intHit = (intCnt_r == intTime_r);

   wire [ROW_W-1:0] leftPtrNxt = (!onRight) ? rowInc(leftPtr_r) : leftPtr_r;
   wire [ROW_W-1:0] rightPtrNxt = identical ? leftPtrNxt :
                                  (advance && intHit && !rightActive_r) ? '0 :
                                  (advance && rightActive_r) ? rowInc(rightPtr_r) : rightPtr_r;
   wire [ROW_W-1:0] intCntNxt = (advance && !intHit) ? rowInc(intCnt_r) : intCnt_r;

   // ======================================================================
   // Row pointers, integration counter and mode 2 phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         leftPtr_r <= '0;
         rightPtr_r <= '0;
         intCnt_r <= '0;
         rightActive_r <= 1'b0;
         firstRow_r <= 1'b1;
         phase_r <= PH_LEFT;
      end else if (framePulse) begin
         leftPtr_r <= '0;
         rightPtr_r <= '0;
         intCnt_r <= '0;
         rightActive_r <= 1'b0;
         firstRow_r <= 1'b1;
         phase_r <= PH_LEFT;
      end else if (rowPulse) begin
         leftPtr_r <= leftPtrNxt;
         rightPtr_r <= rightPtrNxt;
         intCnt_r <= intCntNxt;
         rightActive_r <= rightActive_r || (advance && intHit);
         firstRow_r <= 1'b0;
         case (phase_r)
            PH_LEFT: phase_r <= mode2 ? PH_RIGHT : PH_LEFT;
            PH_RIGHT: phase_r <= PH_LEFT;
            default: phase_r <= PH_LEFT;
         endcase
      end
   end

   // ======================================================================
   // Row strobes and analog control levels
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         leftRowClk_r <= 1'b0;
         rightRowClk_r <= 1'b0;
         leftRowReset_r <= 1'b0;
         rightRowReset_r <= 1'b0;
         colPrecharge_r <= 1'b0;
         calCoarse_r <= 1'b0;
      end else if (ce) begin
         leftRowClk_r <= rowPulse && leftClkNxt;
         rightRowClk_r <= rowPulse && rightClkNxt;
         leftRowReset_r <= rowPulse && leftClkNxt && leftResetNxt;
         rightRowReset_r <= rowPulse && rightClkNxt && rightResetNxt;
         colPrecharge_r <= rowPulse && !seqCfg_r[SEQ_CC];
         if (rowPulse) begin
            calCoarse_r <= firstRow_r ? !seqCfg_r[SEQ_FCAL] : !seqCfg_r[SEQ_LCAL];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         doubleSample_r <= 1'b1;
         resetBusDark_r <= 1'b0;
         blackHold_r <= 1'b0;
         globalPixelReset_r <= 1'b0;
         contCharge_r <= 1'b0;
         convSrc_r <= 1'b0;
         gamma_r <= 1'b0;
         adcDataOut_r <= '0;
      end else if (ce) begin
         doubleSample_r <= !ndrOn;
         resetBusDark_r <= ndrOn || black;
         blackHold_r <= black;
         globalPixelReset_r <= seqCfg_r[SEQ_RALL];
         contCharge_r <= seqCfg_r[SEQ_CC];
         convSrc_r <= adcCfg_r[ADC_EXTCLK];
         gamma_r <= adcCfg_r[ADC_GAMMA];
         adcDataOut_r <= adcCfg_r[ADC_FLIP] ? ~adcDataIn : adcDataIn;
      end
   end

   // ======================================================================
   // Blanking and column timing
   assign sq.gran = seqCfg_r[SEQ_GRAN_HI:SEQ_GRAN_LO];
   assign sq.start = rowPulse;

   irs_blank_timer u_timer (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .sq(sq)
   );

   // ======================================================================
   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign leftRowClk = leftRowClk_r;
   assign rightRowClk = rightRowClk_r;
   assign leftRowReset = leftRowReset_r;
   assign rightRowReset = rightRowReset_r;
   assign leftPtr = leftPtr_r;
   assign rightPtr = rightPtr_r;
   assign doubleSample = doubleSample_r;
   assign resetBusDark = resetBusDark_r;
   assign blackHold = blackHold_r;
   assign colAmpDisconnect = blackHold_r;
   assign globalPixelReset = globalPixelReset_r;
   assign continuousColumnCharge = contCharge_r;
   assign colPrecharge = colPrecharge_r;
   assign calActive = sq.blanking;
   assign calCoarse = calCoarse_r;
   assign colShiftClk = sq.colShiftClk;
   assign xSeqTick = sq.xSeqTick;
   assign adcDataOut = adcDataOut_r;
   assign converterClockSource = convSrc_r;
   assign gammaLaw = gamma_r;

   // ======================================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_double_sample: assert property (rowPulse && !ndrOn |=>
      leftRowClk_r && leftRowReset_r && doubleSample_r)
      else $error("normal row read without reset between samples");
   chk_ndr_read: assert property (rowPulse && ndrOn && ndSet == ND_M1_READ
      && !seqCfg_r[SEQ_RBR] |=> leftRowClk_r && !leftRowReset_r)
      else $error("non-destructive read frame reset a row");
   chk_mode1_same: assert property (rowPulse && mode1 |=>
      leftRowClk_r && rightRowClk_r && (leftRowReset_r == rightRowReset_r))
      else $error("mode 1 row clocks differ");
   chk_mode2_alt: assert property (rowPulse && mode2 && !fastRst |=>
      (leftRowClk_r != rightRowClk_r) && (phase_r != $past(phase_r)))
      else $error("mode 2 rows not alternating");
   chk_set3_order: assert property (rowPulse && ndrOn && ndSet == ND_M2_RESET && !fastRst
      && phase_r == PH_LEFT |=> leftRowClk_r && leftRowReset_r && !rightRowClk_r)
      else $error("setting 3 left row not reset and read");
   chk_set4_noreset: assert property (rowPulse && ndrOn && ndSet == ND_M2_READ
      && !seqCfg_r[SEQ_RBR] |=> !leftRowReset_r && !rightRowReset_r)
      else $error("setting 4 reset a row");
   chk_dark_bus: assert property (ce && ndrOn |=> resetBusDark_r)
      else $error("reset buses not at dark level");
   chk_right_noreset: assert property (rowPulse && onRight && !fastRst |=>
      rightRowClk_r && !rightRowReset_r)
      else $error("mode 2 right row reset");
   chk_fast_same: assert property (rowPulse && fastRst |=> leftRowClk_r && rightRowClk_r)
      else $error("fast reset rows not identical");
   chk_frame_cal: assert property (rowPulse && firstRow_r |=>
      calCoarse_r == !$past(seqCfg_r[SEQ_FCAL]) && calActive)
      else $error("frame calibration mode not applied");
   chk_global_hold: assert property (ce && seqCfg_r[SEQ_RALL] |=> globalPixelReset_r)
      else $error("global pixel reset not held");
   chk_bit_flip: assert property (ce && adcCfg_r[ADC_FLIP] |=>
      adcDataOut_r == ~$past(adcDataIn))
      else $error("converter bits not inverted");
   chk_ptr_step: assert property (rowPulse && !mode2 && !framePulse |=>
      leftPtr_r == rowInc($past(leftPtr_r)))
      else $error("row pointer did not advance");

   cov_mode2_right: cover property (rowPulse && onRight ##1 rightRowClk_r);
   cov_fast_reset: cover property (rowPulse && fastRst);
   cov_ndr_read: cover property (rowPulse && ndrOn && ndSet == ND_M1_READ);
endmodule : irs_readout_top
`default_nettype wire

// *** sim/irs_ctrl_model.sv ***
// Camera controller model driving the frame and row pins
`timescale 1ns/1ps
`default_nettype none
module irs_ctrl_model (
   // Clock and status
   input wire logic clk,
   input wire logic calActive,
   // Controller pins
   output logic rowClkPin,
   output logic frameStartPin
);
   initial begin
      rowClkPin = 1'b0;
      frameStartPin = 1'b0;
   end
   // Frame start comes before the reset frame and every read frame
   task automatic frame();
      frameStartPin <= 1'b1;
      repeat (4) @(posedge clk);
      frameStartPin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : frame
   // Next row clock only after blanking ends; returns blanking length
   task automatic row(output int n);
      n = 0;
      rowClkPin <= 1'b1;
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk);
         if (i == 3) rowClkPin <= 1'b0;
         if (calActive === 1'b1) n++;
         else if (n > 0) break;
      end
   endtask : row
endmodule : irs_ctrl_model
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench of the readout sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import irs_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, v;
   logic [9:0] adcDataIn = 10'h000, adcDataOut;
   logic [11:0] leftPtr, rightPtr, p0;
   logic pready, pslverr, rowClkPin, frameStartPin, leftRowClk, rightRowClk, e;
   logic leftRowReset, rightRowReset, doubleSample, resetBusDark, blackHold, colAmpDisconnect;
   logic globalPixelReset, continuousColumnCharge, colPrecharge, calActive, calCoarse;
   logic colShiftClk, xSeqTick, converterClockSource, gammaLaw;
   int nErrors = 0, checksDone = 0, cyc = 0, lc, rc, lr, rr, pc, n;
   int bl[4] = '{142, 282, 562, 1122};
   irs_readout_top dut (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rowClkPin, .frameStartPin, .leftRowClk, .rightRowClk,
      .leftRowReset, .rightRowReset, .leftPtr, .rightPtr, .doubleSample, .resetBusDark,
      .blackHold, .colAmpDisconnect, .globalPixelReset, .continuousColumnCharge,
      .colPrecharge, .calActive, .calCoarse, .colShiftClk, .xSeqTick, .adcDataIn,
      .adcDataOut, .converterClockSource, .gammaLaw);
   irs_ctrl_model pm (.clk, .calActive, .rowClkPin, .frameStartPin);
   always #10 clk = ~clk;
   // ==========================================================================
   // Pulse counters and timeout
   always @(posedge clk) begin
      cyc++;
      if (leftRowClk === 1'b1) lc++;
      if (rightRowClk === 1'b1) rc++;
      if (leftRowReset === 1'b1) lr++;
      if (rightRowReset === 1'b1) rr++;
      if (colPrecharge === 1'b1) pc++;
      if (cyc == 20000) begin
         nErrors++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (nErrors == 0 && checksDone > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      check("prdata", r, x);
      check("pslverr", 32'(e), 32'(xe));
   endtask : rd
   // Two rows of one frame; a negative expectation is not checked
   task automatic pair(input logic [11:0] m, input int el, er, ql, qr, ep);
      apb(1'b1, 8'h00, 32'(m));
      pm.frame();
      {lc, rc, lr, rr} = '0;
      p0 = leftPtr;
      pm.row(n);
      pm.row(n);
      if (el >= 0) check("leftClk", lc, el);
      if (er >= 0) check("rightClk", rc, er);
      if (ql >= 0) check("leftRst", lr, ql);
      if (qr >= 0) check("rightRst", rr, qr);
      check("ptrStep", 32'(leftPtr - p0), ep);
   endtask : pair
   initial begin
      void'($urandom(32'h5A1D));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h100, 1'b0);
      rd(8'h30, 32'h000, 1'b0);
      rd(8'h0C, 32'h001, 1'b0);
      rd(8'hFC, 32'h000, 1'b1);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 8'h34 + 8'(4 * i), 32'hFFF);
         rd(8'h34 + 8'(4 * i), 32'h0, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         v = $urandom & 32'hFFF;
         apb(1'b1, 8'h00, v);
         repeat (3) @(posedge clk);
         check("doubleSample", doubleSample, !v[0]);
         check("resetBusDark", resetBusDark, v[0] | v[10]);
         check("black", {blackHold, colAmpDisconnect}, {2{v[10]}});
         check("globalReset", globalPixelReset, v[11]);
         check("contCharge", continuousColumnCharge, v[7]);
         rd(8'h00, v, 1'b0);
         v = $urandom & 32'h7FF;
         apb(1'b1, 8'h30, v);
         adcDataIn <= 10'($urandom);
         repeat (3) @(posedge clk);
         check("clkSource", converterClockSource, v[4]);
         check("gammaLaw", gammaLaw, v[9]);
         check("adcOut", adcDataOut, adcDataIn ^ {10{v[10]}});
         e = colShiftClk;
         @(posedge clk);
         check("colShift", colShiftClk, !e);
         ce <= 1'b0;
         @(posedge clk);
         e = colShiftClk;
         @(posedge clk);
         check("ceFreeze", colShiftClk, e);
         ce <= 1'b1;
      end
      for (int g = 0; g < 4; g++) begin
         apb(1'b1, 8'h00, 32'(g << 8) | 32'h040 | 32'((g & 1) << 7));
         pm.frame();
         pc = 0;
         pm.row(n);
         check("blank", n, bl[g]);
         check("coarse", calCoarse, 1'b1);
         do @(posedge clk); while (xSeqTick !== 1'b1);
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (xSeqTick !== 1'b1);
         check("xSeq", n, 2 << g);
         pm.row(n);
         check("coarse", calCoarse, 1'b0);
         check("precharge", pc, (g & 1) ? 0 : 2);
      end
      pair(12'h001, 2, 2, -1, -1, 2);
      pair(12'h003, 2, 2, 0, 0, 2);
      pair(12'h005, 1, 1, 1, 0, 1);
      pair(12'h007, 1, 1, 0, 0, 1);
      pair(12'h00F, 1, 1, 1, 0, 1);
      pair(12'h008, 2, -1, 2, -1, 2);
      pair(12'h010, 2, 2, -1, -1, 2);
      rd(8'h40, 32'h0002_0002, 1'b0);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
